// ---- verilog/atcs_pkg.sv ----
// package of constants for the angular timer configuration and status block
package atcs_pkg;
  // ==========================================================
  // register offsets
  localparam logic [2:0] OFS_CONTROL_ONE = 3'h0;
  localparam logic [2:0] OFS_CLOCK_SELECT = 3'h1;
  localparam logic [2:0] OFS_INPUT_SELECT = 3'h2;
  localparam logic [2:0] OFS_RES_HIGH = 3'h3;
  localparam logic [2:0] OFS_RES_LOW = 3'h4;
  localparam logic [2:0] OFS_PERIOD_HIGH = 3'h5;
  localparam logic [2:0] OFS_PERIOD_LOW = 3'h6;
  localparam logic [2:0] OFS_PHASE_HIGH = 3'h7;
  // ==========================================================
  // control one and clock select field positions, field widths
  localparam int BIT_PHASE_POL = 6;
  localparam int BIT_PERIOD_POL = 4;
  localparam int BIT_MISS_POL = 2;
  localparam int BIT_ACCEL = 1;
  localparam int BIT_VALID = 0;
  localparam int BIT_CLOCK_SRC = 0;
  localparam int RES_WIDTH = 10;
  localparam int PER_WIDTH = 15;
  // ==========================================================
  // reset values and counts
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [1:0] VALID_CYCLES = 2'h2;
  // ==========================================================
  // input select codes
  typedef enum logic [2:0] {
    SEL_PIN = 3'b000,
    SEL_CMP1 = 3'b001,
    SEL_CMP2 = 3'b010,
    SEL_ZCD = 3'b011,
    SEL_LC1 = 3'b100,
    SEL_LC2 = 3'b101
  } atcs_sel_t;
endpackage

// ---- verilog/atcs_top.sv ----
// angular timer configuration, status, input mux and output polarity
`timescale 1ns/10ps
module atcs_top
  import atcs_pkg::*;
(
  input wire logic clk, // system clock
  input wire logic reset, // synchronous reset
  input wire logic [2:0] addr, // register index
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [7:0] rdata, // read data, cycle after rd
  input wire logic pin_routed_input, // external pin
  input wire logic comparator1_synced, // comparator 1
  input wire logic comparator2_synced, // comparator 2
  input wire logic zero_cross_output, // zero-cross detector
  input wire logic logic_cell1_output, // logic cell 1
  input wire logic logic_cell2_output, // logic cell 2
  input wire logic period_event, // new period measured, one pulse
  input wire logic [PER_WIDTH-1:0] measured_period, // period counter value
  input wire logic [RES_WIDTH-1:0] phase_count, // live phase counter
  input wire logic phase_clk_raw, // phase clock, active high
  input wire logic period_clk_raw, // period clock, active high
  input wire logic miss_raw, // missing pulse, active high
  output logic measured_signal, // selected input, synced
  output logic clock_source_select, // 1 internal oscillator, 0 system
  output logic [RES_WIDTH-1:0] resolution_value, // phase resolution
  output logic phase_clk_out, // phase clock with polarity
  output logic period_clk_out, // period clock with polarity
  output logic miss_out, // missing pulse with polarity
  output logic meas_valid // valid status
);

  // ==========================================================
  // registers
  logic phase_out_polarity;
  logic period_out_polarity;
  logic miss_out_polarity;
  logic accel_sign;
  atcs_sel_t input_sel;
  logic [2:0] input_sel_raw;
  logic [PER_WIDTH-1:0] last_period;
  logic [1:0] valid_count;
  logic mux_raw;
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic input_edge;
  logic res_write;

  // write strobe decode
  function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
    hit = (a == ofs);
  endfunction

  assign res_write = wr && (hit(addr, OFS_RES_HIGH) || hit(addr, OFS_RES_LOW));
  assign input_sel = atcs_sel_t'(input_sel_raw);

  // control one writable polarity bits
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_out_polarity <= 1'b0;
      period_out_polarity <= 1'b0;
      miss_out_polarity <= 1'b0;
    end else if (wr && hit(addr, OFS_CONTROL_ONE)) begin
      phase_out_polarity <= wdata[BIT_PHASE_POL];
      period_out_polarity <= wdata[BIT_PERIOD_POL];
      miss_out_polarity <= wdata[BIT_MISS_POL];
    end
  end

  // clock select and input select
  always_ff @(posedge clk) begin
    if (reset) begin
      clock_source_select <= 1'b0;
      input_sel_raw <= 3'b000;
    end else if (wr) begin
      if (hit(addr, OFS_CLOCK_SELECT)) begin
        clock_source_select <= wdata[BIT_CLOCK_SRC];
      end
      if (hit(addr, OFS_INPUT_SELECT)) begin
        input_sel_raw <= wdata[2:0];
      end
    end
  end

  // resolution halves
  always_ff @(posedge clk) begin
    if (reset) begin
      resolution_value <= '0;
    end else if (wr && hit(addr, OFS_RES_HIGH)) begin
      resolution_value[9:8] <= wdata[1:0];
    end else if (wr && hit(addr, OFS_RES_LOW)) begin
      resolution_value[7:0] <= wdata;
    end
  end

  // input source mux, reserved codes idle low
  always_comb begin
    case (input_sel)
      SEL_PIN: mux_raw = pin_routed_input;
      SEL_CMP1: mux_raw = comparator1_synced;
      SEL_CMP2: mux_raw = comparator2_synced;
      SEL_ZCD: mux_raw = zero_cross_output;
      SEL_LC1: mux_raw = logic_cell1_output;
      SEL_LC2: mux_raw = logic_cell2_output;
      default: mux_raw = 1'b0;
    endcase
  end

  // two-stage synchroniser plus edge stage
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
    end else begin
      sync_a <= mux_raw;
      sync_b <= sync_a;
      sync_c <= sync_b;
    end
  end

  assign input_edge = sync_b && !sync_c;
  assign measured_signal = sync_b;

  // valid counter over input cycles
  always_ff @(posedge clk) begin
    if (reset || res_write) begin
      valid_count <= 2'h0;
    end else if (input_edge && valid_count != VALID_CYCLES) begin
      valid_count <= valid_count + 2'h1;
    end
  end

  assign meas_valid = (valid_count == VALID_CYCLES);

  // acceleration sign from successive periods
  always_ff @(posedge clk) begin
    if (reset) begin
      accel_sign <= 1'b0;
      last_period <= '0;
    end else if (period_event) begin
      accel_sign <= (measured_period < last_period);
      last_period <= measured_period;
    end
  end

  // outputs muted while invalid, then polarity applied
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_clk_out <= 1'b0;
      period_clk_out <= 1'b0;
      miss_out <= 1'b0;
    end else begin
      phase_clk_out <= (meas_valid && phase_clk_raw) ^ phase_out_polarity;
      period_clk_out <= (meas_valid && period_clk_raw) ^ period_out_polarity;
      miss_out <= (meas_valid && miss_raw) ^ miss_out_polarity;
    end
  end

  // read data, unimplemented bits zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= ZERO_BYTE;
    end else if (rd) begin
      rdata <= ZERO_BYTE;
      case (addr)
        OFS_CONTROL_ONE: begin
          rdata[BIT_PHASE_POL] <= phase_out_polarity;
          rdata[BIT_PERIOD_POL] <= period_out_polarity;
          rdata[BIT_MISS_POL] <= miss_out_polarity;
          rdata[BIT_ACCEL] <= accel_sign;
          rdata[BIT_VALID] <= meas_valid;
        end
        OFS_CLOCK_SELECT: rdata[BIT_CLOCK_SRC] <= clock_source_select;
        OFS_INPUT_SELECT: rdata[2:0] <= input_sel_raw;
        OFS_RES_HIGH: rdata[1:0] <= resolution_value[9:8];
        OFS_RES_LOW: rdata <= resolution_value[7:0];
        OFS_PERIOD_HIGH: rdata[6:0] <= measured_period[14:8];
        OFS_PERIOD_LOW: rdata <= measured_period[7:0];
        OFS_PHASE_HIGH: rdata[1:0] <= phase_count[9:8];
        default: rdata <= ZERO_BYTE;
      endcase
    end else begin
      rdata <= ZERO_BYTE;
    end
  end

endmodule // atcs_top

// ---- tb/atcs_pulse_src.sv ----
// periodic pulse source standing in for the measured signal sources
`timescale 1ns/10ps
module atcs_pulse_src #(
  parameter int HALF = 3 // half period in clocks
) (
  input wire logic clk, // system clock
  output logic pulse // square wave
);
  int n = 0;
  initial pulse = 1'b0;
  // toggle every half period
  always @(posedge clk) begin
    n <= (n == HALF - 1) ? 0 : n + 1;
    if (n == HALF - 1) pulse <= ~pulse;
  end
endmodule // atcs_pulse_src

// ---- tb/atcs_top_monitor.sv ----
// assertion checker for the angular timer configuration block
`timescale 1ns/10ps
module atcs_top_monitor
  import atcs_pkg::*;
(
  input wire logic clk, reset, wr, rd, meas_valid, clock_source_select, // control
  input wire logic [2:0] addr, // register index
  input wire logic [7:0] wdata, rdata, // bus data
  input wire logic phase_clk_raw, period_clk_raw, miss_raw, // raw pulses
  input wire logic phase_clk_out, period_clk_out, miss_out, // shaped pulses
  input wire logic [RES_WIDTH-1:0] resolution_value // resolution
);
  logic [7:0] pol;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // shadow of the polarity bits
  always_ff @(posedge clk) begin
    if (reset) pol <= ZERO_BYTE;
    else if (wr && addr == OFS_CONTROL_ONE) pol <= wdata;
  end
  sequence res_wr; wr && (addr == OFS_RES_HIGH || addr == OFS_RES_LOW); endsequence
  sequence live; meas_valid && $past(meas_valid) && $stable(pol); endsequence
  a_phase_pol: assert property (live |-> phase_clk_out ==
    ($past(phase_clk_raw) ^ pol[BIT_PHASE_POL])) else $error("phase polarity");
  a_period_pol: assert property (live |-> period_clk_out ==
    ($past(period_clk_raw) ^ pol[BIT_PERIOD_POL])) else $error("period polarity");
  a_miss_pol: assert property (live |-> miss_out ==
    ($past(miss_raw) ^ pol[BIT_MISS_POL])) else $error("miss polarity");
  a_write_clears_valid: assert property (res_wr |=> !meas_valid [*2])
    else $error("valid not cleared");
  a_res_low_load: assert property (wr && addr == OFS_RES_LOW |=>
    resolution_value[7:0] == $past(wdata)) else $error("res low");
  a_res_high_load: assert property (wr && addr == OFS_RES_HIGH |=>
    resolution_value[9:8] == $past(wdata[1:0])) else $error("res high");
  a_clk_sel_load: assert property (wr && addr == OFS_CLOCK_SELECT |=>
    clock_source_select == $past(wdata[0])) else $error("clock select");
  a_idle_read_zero: assert property (!rd |=> rdata == ZERO_BYTE)
    else $error("rdata without read");
  a_clk_sel_pad: assert property (rd && addr == OFS_CLOCK_SELECT |=>
    rdata[7:1] == 7'h00) else $error("clock select pad");
endmodule // atcs_top_monitor
bind atcs_top atcs_top_monitor u_mon (.clk, .reset, .wr, .rd, .meas_valid,
  .clock_source_select, .addr, .wdata, .rdata, .phase_clk_raw, .period_clk_raw, .miss_raw,
  .phase_clk_out, .period_clk_out, .miss_out, .resolution_value);

// ---- tb/atcs_top_tb.sv ----
// self-checking bench for the angular timer configuration block
`timescale 1ns/10ps
module atcs_top_tb
  import atcs_pkg::*;
;
  logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, period_event = 1'b0, pulse;
  logic phase_clk_raw = 1'b0, period_clk_raw = 1'b0, miss_raw = 1'b0;
  logic [2:0] addr = 3'h0, route = 3'h6;
  logic [7:0] wdata = 8'h00, rdata;
  logic [14:0] measured_period = 15'h0000;
  logic [14:0] per_tab [4] = '{15'h0064, 15'h0032, 15'h0032, 15'h003c};
  logic [3:0] sgn = 4'b0010;
  logic [9:0] phase_count = 10'h2ff, resolution_value;
  logic [5:0] src;
  logic measured_signal, clock_source_select, phase_clk_out, period_clk_out, miss_out;
  logic meas_valid;
  int bad_count = 0, cmp_count = 0;
  // route the pulse to one source, to none (code 6), or to all of them
  assign src = (route == 3'h7) ? {6{pulse}} : 6'(pulse) << route;
  atcs_top uut (.clk, .reset, .addr, .wdata, .wr, .rd, .rdata, .pin_routed_input(src[0]),
    .comparator1_synced(src[1]), .comparator2_synced(src[2]), .zero_cross_output(src[3]),
    .logic_cell1_output(src[4]), .logic_cell2_output(src[5]), .period_event, .measured_period,
    .phase_count, .phase_clk_raw, .period_clk_raw, .miss_raw, .measured_signal,
    .clock_source_select, .resolution_value, .phase_clk_out, .period_clk_out, .miss_out,
    .meas_valid);
  atcs_pulse_src #(.HALF(3)) src_model (.clk, .pulse);
  initial forever #10 clk = ~clk;
  // ==========================================================
  // bus tasks and comparison
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    cmp({8'h00, rdata}, {8'h00, e});
    @(posedge clk);
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // test sequence
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rchk(OFS_CONTROL_ONE, 8'h00);
    wreg(OFS_CLOCK_SELECT, 8'hff);
    rchk(OFS_CLOCK_SELECT, 8'h01);
    cmp({15'h0000, clock_source_select}, 16'h0001);
    wreg(OFS_RES_HIGH, 8'hff);
    wreg(OFS_RES_LOW, 8'ha5);
    rchk(OFS_RES_HIGH, 8'h03);
    rchk(OFS_RES_LOW, 8'ha5);
    cmp({6'h00, resolution_value}, 16'h03a5);
    wreg(OFS_INPUT_SELECT, 8'hff);
    rchk(OFS_INPUT_SELECT, 8'h07);
    wreg(OFS_CONTROL_ONE, 8'hff);
    rchk(OFS_CONTROL_ONE, 8'h54);
    // every select code, reserved ones with all sources pulsing
    for (int k = 0; k < 8; k++) begin
      route <= (k < 6) ? 3'(k) : 3'h7;
      wreg(OFS_INPUT_SELECT, 8'(k));
      wreg(OFS_RES_LOW, 8'h00);
      rchk(OFS_CONTROL_ONE, 8'h54);
      repeat (20) @(posedge clk);
      rchk(OFS_CONTROL_ONE, 8'h54 | 8'(k < 6));
      if (k >= 6) cmp({15'h0000, measured_signal}, 16'h0000);
    end
    wreg(OFS_INPUT_SELECT, 8'h00);
    repeat (20) @(posedge clk);
    // output polarity both ways
    for (int j = 0; j < 2; j++) begin
      wreg(OFS_CONTROL_ONE, j ? 8'h54 : 8'h00);
      for (int r = 0; r < 2; r++) begin
        {phase_clk_raw, period_clk_raw, miss_raw} <= {3{r[0]}};
        repeat (3) @(posedge clk);
        @(negedge clk);
        cmp({phase_clk_out, period_clk_out, miss_out}, {3{r[0] ^ j[0]}});
        @(posedge clk);
      end
    end
    // acceleration sign over successive periods
    for (int i = 0; i < 4; i++) begin
      measured_period <= per_tab[i];
      period_event <= 1'b1;
      @(posedge clk);
      period_event <= 1'b0;
      @(posedge clk);
      rchk(OFS_CONTROL_ONE, {6'h15, sgn[i], 1'b1});
    end
    rchk(OFS_PHASE_HIGH, 8'h02);
    rchk(OFS_PERIOD_LOW, 8'h3c);
    rchk(OFS_PERIOD_HIGH, 8'h00);
    print_verdict();
  end
  // watchdog against a hang
  initial begin
    #100000;
    bad_count++;
    print_verdict();
  end
endmodule // atcs_top_tb
